// File: hw/spsr_params.svh
`ifndef SPSR_PARAMS_SVH
`define SPSR_PARAMS_SVH
// ******************************
// register byte offsets
// ******************************
`define SPSR_A_CMD 8'h00
`define SPSR_A_TGT 8'h04
`define SPSR_A_CFG 8'h08
`define SPSR_A_ENDS 8'h0C
`define SPSR_A_VEL 8'h10
`define SPSR_A_ST1 8'h14
`define SPSR_A_ST2 8'h18
// ******************************
// command codes, fields, resets
// ******************************
`define SPSR_C_SETPOS 4'h1
`define SPSR_C_GOSAFE 4'h2
`define SPSR_C_REFRUN 4'h3
`define SPSR_C_HALT 4'h4
`define SPSR_CFG_SEC 26:16
`define SPSR_CFG_MODE 1:0
`define SPSR_VEL_VMIN 3:0
`define SPSR_VEL_VMAX 7:4
`define SPSR_VEL_RMIN 11:8
`define SPSR_VEL_RMAX 15:12
`define SPSR_VEL_ACC 19:16
`define SPSR_SEC_OFF 11'h400
`define SPSR_CFG_RST 32'h0400_0000
`define SPSR_VEL_RST 32'h0000_0010
// ******************************
// timing
// ******************************
`define SPSR_CLK_MHZ 125
`define SPSR_STEP_US 64
`define SPSR_STEP_CYC (`SPSR_STEP_US * `SPSR_CLK_MHZ)
`endif

// File: hw/spsr_pkg.sv
package spsr_pkg;
   typedef enum logic [1:0] {
      MODE_HALF, MODE_QTR, MODE_EIGHTH, MODE_SIXTEENTH
   } spsr_mode_t;
   typedef enum logic [3:0] {
      ST_INACTIVE, ST_STOPPED, ST_GOTO, ST_REF1, ST_REF2,
      ST_REFSAFE, ST_DEADLOCK, ST_HALTWAIT, ST_SHUTDOWN
   } spsr_state_t;
   // analog monitor levels, high when the condition holds
   typedef struct packed {
      logic over_temp;
      logic temp_warn_hi;
      logic temp_warn_lo;
      logic upper_undervoltage_level;
      logic lower_undervoltage_level;
      logic electrical_defect;
      logic charge_pump_fail;
   } spsr_sense_t;
   typedef struct packed {
      logic [15:0] goal;
      logic [3:0] vstart;
      logic [3:0] vtop;
      logic [3:0] acc;
      logic ramp;
   } spsr_move_t;
endpackage

// File: hw/spsr_range.sv
`timescale 1ns/1ps
`include "spsr_params.svh"
module spsr_range
   import spsr_pkg::*;
(
   // mode and raw values
   input wire spsr_mode_t i_mode,
   input wire logic [15:0] i_value,
   input wire logic [10:0] i_secure,
   // results
   output logic [15:0] o_clamped,
   output logic [15:0] o_secure,
   output logic o_sec_en
);
   logic signed [16:0] lim;
   logic signed [16:0] val;
   always_comb begin
      lim = 17'sh01000 <<< i_mode;
      val = {i_value[15], i_value};
      o_clamped = i_value;
      if (i_mode != MODE_SIXTEENTH) begin
         if (val > lim - 17'sh00001) o_clamped = lim[15:0] - 16'h0001;
         if (val < -lim) o_clamped = 16'h0000 - lim[15:0];
      end
      o_secure = {{5{i_secure[10]}}, i_secure} << (3'h2 + {1'b0, i_mode});
      o_sec_en = i_secure != `SPSR_SEC_OFF;
   end
endmodule

// File: hw/spsr_mover.sv
`timescale 1ns/1ps
module spsr_mover
   import spsr_pkg::*;
#(
   parameter int STEP_CYC = 8000
)(
   // clock and reset
   input wire logic i_clock,
   input wire logic i_nrst,
   // control
   input wire spsr_move_t i_move,
   input wire logic i_run,
   input wire logic i_clear,
   // state
   output logic [15:0] o_pos,
   output logic o_done,
   output logic o_step,
   output logic o_dir
);
   logic [15:0] pos_q, pos_d;
   logic [31:0] cnt_q, cnt_d, period;
   logic [3:0] vel_q, vel_d, accn_q, accn_d;
   logic step_q, step_d, dir_q, dir_d;
   assign o_pos = pos_q;
   assign o_done = pos_q == i_move.goal;
   assign o_step = step_q;
   assign o_dir = dir_q;
   always_comb begin
      period = (STEP_CYC >> 5) * (32'd32 - {28'h0, vel_q});
      pos_d = pos_q;
      cnt_d = cnt_q;
      vel_d = vel_q;
      accn_d = accn_q;
      step_d = 1'b0;
      dir_d = dir_q;
      if (i_clear) begin
         pos_d = 16'h0000;
         cnt_d = 32'h0;
      end else if (!i_run || o_done) begin
         cnt_d = 32'h0;
         vel_d = i_move.vstart;
         accn_d = 4'h0;
      end else if (cnt_q >= period) begin
         cnt_d = 32'h0;
         step_d = 1'b1;
         dir_d = $signed(i_move.goal) > $signed(pos_q);
         pos_d = dir_d ? pos_q + 16'h0001 : pos_q - 16'h0001;
         accn_d = accn_q + 4'h1;
         if (i_move.ramp && vel_q < i_move.vtop &&
             accn_q >= 4'hF - i_move.acc) begin
            vel_d = vel_q + 4'h1;
            accn_d = 4'h0;
         end
      end else begin
         cnt_d = cnt_q + 32'h1;
      end
   end
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         pos_q <= 16'h0000;
         cnt_q <= 32'h0;
         vel_q <= 4'h0;
         accn_q <= 4'h0;
         step_q <= 1'b0;
         dir_q <= 1'b0;
      end else begin
         pos_q <= pos_d;
         cnt_q <= cnt_d;
         vel_q <= vel_d;
         accn_q <= accn_d;
         step_q <= step_d;
         dir_q <= dir_d;
      end
   end
endmodule

// File: hw/spsr_top.sv
// Summary of operation
// R1: positions two's complement, range per stepping mode
// R2: set-target command; status two reports position
// R3: secure position 11 bits, coarse resolution
// R4: go-to-safe command drives to secure position
// R5: status one shows switch flag, zero open
// R6: switch changes cause no automatic action
// R7: temp, undervoltage, defect, pump fail shut down
// R8: shutdown: bridges high-z, target takes position
// R9: bus stays fully working during shutdown
// R10: exit needs causes gone, then status one
// R11: exit: hold current, clock on, pump on
// R12: host activates device with status one first
// R13: host should run reference search after faults
// R14: reference command starts two-phase search
// R15: first motion ramps with vmax, vmin, acceleration
// R16: second motion constant speed at vmin
// R17: after second motion, position cleared to zero
// R18: then secure position only if enabled
// R19: search ignores commands except halt, shutdown
// R20: host keeps search ends distinct from position
// R21: deadlock left by halt then status one
// R22: two temp warnings, undervoltage warning, shutdowns
// R23: set-target, go-safe ignored while steps lost
`timescale 1ns/1ps
`include "spsr_params.svh"
module spsr_top
   import spsr_pkg::*;
#(
   parameter int STEP_CYC = `SPSR_STEP_CYC
)(
   // clock and reset
   input wire logic i_clock,
   input wire logic i_nrst,
   // apb slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // monitors and switch
   input wire spsr_sense_t i_sense,
   input wire logic i_ext_switch_input,
   input wire logic i_lost_step,
   // motor drive
   output logic o_bridge_hiz,
   output logic o_hold_current,
   output logic o_motor_clk_en,
   output logic o_cp_enable,
   output logic o_step,
   output logic o_dir
);
   // ******************************
   // register bus
   // ******************************
   logic [31:0] tgtr_q, tgtr_d, cfg_q, cfg_d, ends_q, ends_d;
   logic [31:0] vel_q, vel_d, rdata_q, rdata_d;
   logic rdy_q, rdy_d, err_q, err_d, acc_done;
   logic cmd_wr, st1_rd;
   logic [3:0] cmd;
   logic [6:0] flag_q, flag_d;
   logic sw_q;
   spsr_state_t state_q, state_d;
   logic [15:0] tgt_q, tgt_d, pos, clamped, secure;
   logic sec_en, done, clr;
   logic mapped;
   assign acc_done = i_psel && i_penable && rdy_q;
   assign cmd_wr = acc_done && i_pwrite && i_paddr == `SPSR_A_CMD;
   assign st1_rd = acc_done && !i_pwrite && i_paddr == `SPSR_A_ST1;
   assign cmd = i_pwdata[3:0];
   always_comb begin
      tgtr_d = tgtr_q;
      cfg_d = cfg_q;
      ends_d = ends_q;
      vel_d = vel_q;
      rdata_d = rdata_q;
      err_d = 1'b0;
      rdy_d = i_psel && i_penable && !rdy_q; // R9
      mapped = i_paddr <= `SPSR_A_ST2 && i_paddr[1:0] == 2'b00;
      if (rdy_d) begin
         err_d = !mapped;
         rdata_d = 32'h0;
         case (i_paddr)
            `SPSR_A_TGT: rdata_d = tgtr_q;
            `SPSR_A_CFG: rdata_d = cfg_q;
            `SPSR_A_ENDS: rdata_d = ends_q;
            `SPSR_A_VEL: rdata_d = vel_q;
            `SPSR_A_ST1: rdata_d = {19'h0, state_q, i_lost_step,
               sw_q, flag_q}; // R5 R22
            `SPSR_A_ST2: rdata_d = {tgt_q, pos}; // R2
            default: rdata_d = 32'h0;
         endcase
      end
      if (acc_done && i_pwrite) begin
         case (i_paddr)
            `SPSR_A_TGT: tgtr_d = {16'h0, i_pwdata[15:0]};
            `SPSR_A_CFG: cfg_d = {5'h0, i_pwdata[26:16], 14'h0,
               i_pwdata[1:0]};
            `SPSR_A_ENDS: ends_d = i_pwdata;
            `SPSR_A_VEL: vel_d = {12'h0, i_pwdata[19:0]};
            default: ;
         endcase
      end
   end
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         tgtr_q <= 32'h0;
         cfg_q <= `SPSR_CFG_RST;
         ends_q <= 32'h0;
         vel_q <= `SPSR_VEL_RST;
         rdata_q <= 32'h0;
         rdy_q <= 1'b0;
         err_q <= 1'b0;
      end else begin
         tgtr_q <= tgtr_d;
         cfg_q <= cfg_d;
         ends_q <= ends_d;
         vel_q <= vel_d;
         rdata_q <= rdata_d;
         rdy_q <= rdy_d;
         err_q <= err_d;
      end
   end
   assign o_prdata = rdata_q;
   assign o_pready = rdy_q;
   assign o_pslverr = err_q;
   // ******************************
   // sticky flags, set wins over clear
   // ******************************
   genvar gi;
   generate
      for (gi = 0; gi < 7; gi++) begin : g_flag
         assign flag_d[gi] = i_sense[gi] || (flag_q[gi] && !st1_rd);
      end
   endgenerate
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         flag_q <= 7'h00;
         sw_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
         sw_q <= i_ext_switch_input; // R5 R6
      end
   end
   // ******************************
   // motion supervisor
   // ******************************
   logic cause, halt;
   logic drv_q, drv_d;
   spsr_move_t move;
   assign cause = i_sense.over_temp || i_sense.lower_undervoltage_level
      || i_sense.electrical_defect || i_sense.charge_pump_fail; // R7 R22
   assign halt = cmd_wr && cmd == `SPSR_C_HALT;
   spsr_range u_range (
      .i_mode(spsr_mode_t'(cfg_q[`SPSR_CFG_MODE])),
      .i_value(tgtr_q[15:0]),
      .i_secure(cfg_q[`SPSR_CFG_SEC]),
      .o_clamped(clamped), // R1
      .o_secure(secure), // R3
      .o_sec_en(sec_en)
   );
   always_comb begin
      state_d = state_q;
      tgt_d = tgt_q;
      clr = 1'b0;
      case (state_q)
         ST_INACTIVE, ST_SHUTDOWN: begin
            if (st1_rd && !cause) state_d = ST_STOPPED; // R10 R11
         end
         ST_STOPPED, ST_GOTO: begin
            if (halt) begin
               state_d = ST_STOPPED;
               tgt_d = pos;
            end else if (cmd_wr && cmd == `SPSR_C_REFRUN) begin // R14
               if (ends_q[15:0] == pos || ends_q[15:0] == ends_q[31:16])
                  state_d = ST_DEADLOCK;
               else begin
                  state_d = ST_REF1;
                  tgt_d = ends_q[15:0];
               end
            end else if (cmd_wr && cmd == `SPSR_C_SETPOS &&
                         !i_lost_step) begin // R23
               state_d = ST_GOTO;
               tgt_d = clamped; // R2
            end else if (cmd_wr && cmd == `SPSR_C_GOSAFE &&
                         !i_lost_step && sec_en) begin // R23
               state_d = ST_GOTO;
               tgt_d = secure; // R4
            end else if (state_q == ST_GOTO && done)
               state_d = ST_STOPPED;
         end
         ST_REF1: begin
            if (halt) begin // R19
               state_d = ST_STOPPED;
               tgt_d = pos;
            end else if (done) begin
               state_d = ST_REF2;
               tgt_d = ends_q[31:16];
            end
         end
         ST_REF2: begin
            if (halt) begin // R19
               state_d = ST_STOPPED;
               tgt_d = pos;
            end else if (done) begin
               clr = 1'b1; // R17
               state_d = sec_en ? ST_REFSAFE : ST_STOPPED; // R18
               tgt_d = sec_en ? secure : 16'h0000;
            end
         end
         ST_REFSAFE: begin
            if (halt) tgt_d = pos;
            if (halt || done) state_d = ST_STOPPED;
         end
         ST_DEADLOCK: begin
            if (halt) state_d = ST_HALTWAIT; // R21
         end
         ST_HALTWAIT: begin
            if (st1_rd) state_d = ST_STOPPED; // R21
         end
         default: state_d = ST_INACTIVE;
      endcase
      if (cause && state_q != ST_INACTIVE) begin // R7
         state_d = ST_SHUTDOWN;
         if (state_q != ST_SHUTDOWN) tgt_d = pos; // R8
         clr = 1'b0;
      end
      drv_d = state_d != ST_INACTIVE && state_d != ST_SHUTDOWN; // R8 R11
   end
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         state_q <= ST_INACTIVE;
         tgt_q <= 16'h0000;
         drv_q <= 1'b0;
      end else begin
         state_q <= state_d;
         tgt_q <= tgt_d;
         drv_q <= drv_d;
      end
   end
   assign o_bridge_hiz = !drv_q;
   assign o_hold_current = drv_q;
   assign o_motor_clk_en = drv_q;
   assign o_cp_enable = drv_q;
   // ******************************
   // stepping engine
   // ******************************
   always_comb begin
      move.goal = tgt_q;
      move.acc = vel_q[`SPSR_VEL_ACC];
      move.ramp = state_q != ST_REF2; // R16
      if (state_q == ST_REF1 || state_q == ST_REF2) begin // R15
         move.vstart = vel_q[`SPSR_VEL_RMIN];
         move.vtop = state_q == ST_REF2 ? vel_q[`SPSR_VEL_RMIN]
            : vel_q[`SPSR_VEL_RMAX];
      end else begin
         move.vstart = vel_q[`SPSR_VEL_VMIN];
         move.vtop = vel_q[`SPSR_VEL_VMAX];
      end
   end
   spsr_mover #(.STEP_CYC(STEP_CYC)) u_mover (
      .i_clock(i_clock),
      .i_nrst(i_nrst),
      .i_move(move),
      .i_run((state_q == ST_GOTO || state_q == ST_REF1 ||
              state_q == ST_REF2 || state_q == ST_REFSAFE) &&
             !halt && !cause), // R8 R19
      .i_clear(clr),
      .o_pos(pos),
      .o_done(done),
      .o_step(o_step),
      .o_dir(o_dir)
   );
   // ******************************
   // checks
   // ******************************
   shut_entry_a: assert property ( // R7
      @(posedge i_clock) disable iff (!i_nrst)
      cause && state_q != ST_INACTIVE |=> state_q == ST_SHUTDOWN)
      else $error("fault did not force shutdown");
   shut_tgt_a: assert property ( // R8
      @(posedge i_clock) disable iff (!i_nrst)
      $rose(state_q == ST_SHUTDOWN) |-> tgt_q == $past(pos)
      && o_bridge_hiz)
      else $error("shutdown entry wrong");
   shut_hold_a: assert property ( // R10
      @(posedge i_clock) disable iff (!i_nrst)
      state_q == ST_SHUTDOWN && !st1_rd |=> state_q == ST_SHUTDOWN)
      else $error("shutdown left without query");
   shut_exit_a: assert property ( // R11
      @(posedge i_clock) disable iff (!i_nrst)
      state_q == ST_SHUTDOWN && st1_rd && !cause |=> state_q == ST_STOPPED
      && o_hold_current && o_cp_enable && o_motor_clk_en)
      else $error("shutdown exit wrong");
   bus_answer_a: assert property ( // R9
      @(posedge i_clock) disable iff (!i_nrst)
      i_psel && i_penable && !o_pready |=> o_pready)
      else $error("bus answer late");
   ref_lock_a: assert property ( // R19
      @(posedge i_clock) disable iff (!i_nrst)
      state_q == ST_REF1 && !cause && !halt ##0 !done
      |=> state_q == ST_REF1)
      else $error("search interrupted");
   ref_zero_a: assert property ( // R17 R18
      @(posedge i_clock) disable iff (!i_nrst)
      state_q == ST_REF2 && done && !halt && !cause |=> pos == 16'h0000
      && (state_q == ST_REFSAFE) == sec_en)
      else $error("search end wrong");
   dead_keep_a: assert property ( // R21
      @(posedge i_clock) disable iff (!i_nrst)
      state_q == ST_DEADLOCK && !halt && !cause
      |=> state_q == ST_DEADLOCK)
      else $error("deadlock left early");
   lost_block_a: assert property ( // R23
      @(posedge i_clock) disable iff (!i_nrst)
      state_q == ST_STOPPED && i_lost_step && !cause && cmd_wr
      && cmd == `SPSR_C_SETPOS |=> state_q == ST_STOPPED)
      else $error("move taken with lost steps");
   switch_flag_a: assert property ( // R5
      @(posedge i_clock) disable iff (!i_nrst)
      !i_ext_switch_input |=> !sw_q)
      else $error("switch flag set while open");
   set_goto_a: assert property ( // R2
      @(posedge i_clock) disable iff (!i_nrst)
      state_q == ST_STOPPED && cmd_wr && cmd == `SPSR_C_SETPOS
      && !i_lost_step && !cause
      |=> state_q == ST_GOTO && tgt_q == $past(clamped))
      else $error("set target not taken");
   safe_goto_a: assert property ( // R4
      @(posedge i_clock) disable iff (!i_nrst)
      state_q == ST_STOPPED && cmd_wr && cmd == `SPSR_C_GOSAFE
      && !i_lost_step && sec_en && !cause
      |=> state_q == ST_GOTO && tgt_q == $past(secure))
      else $error("safe position not taken");
   ref_start_a: assert property ( // R14
      @(posedge i_clock) disable iff (!i_nrst)
      state_q == ST_STOPPED && cmd_wr && cmd == `SPSR_C_REFRUN && !cause
      |=> state_q == ST_REF1 || state_q == ST_DEADLOCK)
      else $error("search not started");
   halt_stop_a: assert property ( // R19
      @(posedge i_clock) disable iff (!i_nrst)
      halt && !cause && (state_q == ST_GOTO || state_q == ST_REF1
      || state_q == ST_REF2 || state_q == ST_REFSAFE)
      |=> state_q == ST_STOPPED && tgt_q == pos)
      else $error("halt did not stop motion");
   step_hiz_a: assert property ( // R8
      @(posedge i_clock) disable iff (!i_nrst)
      o_bridge_hiz |-> !o_step)
      else $error("step issued with bridges off");
   flag_set_a: assert property ( // R22
      @(posedge i_clock) disable iff (!i_nrst)
      i_sense != 7'h00 |=> (flag_q | $past(i_sense)) == flag_q)
      else $error("warning flag not raised");
endmodule

// File: test/spsr_motor_model.sv
`timescale 1ns/1ps
module spsr_motor_model (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_nrst,
   // drive from the block
   input wire logic i_step,
   input wire logic i_dir,
   input wire logic i_bridge_hiz,
   // observed shaft
   output logic [15:0] o_pos,
   output logic o_step_in_hiz
);
   // shaft follows step pulses; steps with bridges off are flagged
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         o_pos <= 16'h0000;
         o_step_in_hiz <= 1'b0;
      end else if (i_step) begin
         o_pos <= i_dir ? o_pos + 16'h0001 : o_pos - 16'h0001;
         if (i_bridge_hiz) begin
            o_step_in_hiz <= 1'b1;
         end
      end
   end
endmodule

// File: test/tb.sv
`timescale 1ns/1ps
`include "spsr_params.svh"
module tb
   import spsr_pkg::*;
;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   spsr_sense_t sense = '0;
   logic sw = 1'b0;
   logic lost = 1'b0;
   logic hiz, hold, clk_en, cp_en, step, dir, bad;
   logic [15:0] shaft;
   int error_cnt = 0;
   int checks_done = 0;

   always #4 clk = ~clk;

   spsr_top #(.STEP_CYC(64)) i_dut (
      .i_clock(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_sense(sense), .i_ext_switch_input(sw), .i_lost_step(lost),
      .o_bridge_hiz(hiz), .o_hold_current(hold), .o_motor_clk_en(clk_en),
      .o_cp_enable(cp_en), .o_step(step), .o_dir(dir)
   );

   spsr_motor_model i_motor (
      .i_clock(clk), .i_nrst(nrst), .i_step(step), .i_dir(dir),
      .i_bridge_hiz(hiz), .o_pos(shaft), .o_step_in_hiz(bad)
   );

   // ******************************
   // common tasks
   // ******************************
   task automatic finish_test();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] seen,
                        input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
      int n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) check("pready", 32'h0, 32'h1);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      logic e;
      apb(1'b0, a, 32'h0, q, e);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask

   task automatic wait_state(input logic [3:0] s);
      logic [31:0] q;
      repeat (600) begin
         rd(`SPSR_A_ST1, q);
         if (q[12:9] === s) break;
      end
      check("state", {28'h0, q[12:9]}, {28'h0, s});
   endtask

   // ******************************
   // scenarios
   // ******************************
   task automatic t_reset();
      logic [31:0] q;
      logic e;
      check("hiz at reset", {31'h0, hiz}, 32'h1);
      rd(`SPSR_A_CFG, q);
      check("cfg reset", q, `SPSR_CFG_RST);
      apb(1'b0, 8'h1C, 32'h0, q, e);
      check("unmapped err", {31'h0, e}, 32'h1);
      rd(`SPSR_A_ST1, q);
      check("inactive", {28'h0, q[12:9]}, 32'h0);
      wait_state(4'h1);
      check("hold on", {31'h0, hold}, 32'h1);
      wr(`SPSR_A_VEL, 32'h0000_FFFF);
   endtask

   task automatic t_range();
      logic [31:0] q;
      for (int m = 0; m < 4; m++) begin
         wr(`SPSR_A_CFG, 32'h0400_0000 | 32'(m));
         wr(`SPSR_A_TGT, 32'h0000_7FFF);
         wr(`SPSR_A_CMD, 32'h1);
         rd(`SPSR_A_ST2, q);
         check("max", {16'h0, q[31:16]}, 32'(1 << (12 + m)) - 32'h1);
         wr(`SPSR_A_CMD, 32'h4);
         wait_state(4'h1);
         wr(`SPSR_A_TGT, 32'h0000_8000);
         wr(`SPSR_A_CMD, 32'h1);
         rd(`SPSR_A_ST2, q);
         check("min", {16'h0, q[31:16]},
               32'h0001_0000 - 32'(1 << (12 + m)));
         wr(`SPSR_A_CMD, 32'h4);
         wait_state(4'h1);
      end
   endtask

   task automatic t_safe();
      logic [31:0] q;
      wr(`SPSR_A_CFG, 32'h0002_0000);
      wr(`SPSR_A_CMD, 32'h2);
      wait_state(4'h1);
      rd(`SPSR_A_ST2, q);
      check("safe pos", {16'h0, q[15:0]}, 32'h8);
      check("shaft", {16'h0, shaft}, {16'h0, q[15:0]});
   endtask

   task automatic t_switch_lost();
      logic [31:0] q;
      logic [31:0] p;
      rd(`SPSR_A_ST2, p);
      rd(`SPSR_A_ST1, q);
      check("switch open", {31'h0, q[7]}, 32'h0);
      sw <= 1'b1;
      lost <= 1'b1;
      repeat (4) @(posedge clk);
      rd(`SPSR_A_ST1, q);
      check("switch closed", {31'h0, q[7]}, 32'h1);
      wr(`SPSR_A_TGT, 32'h0000_0030);
      wr(`SPSR_A_CMD, 32'h1);
      repeat (80) @(posedge clk);
      wr(`SPSR_A_CMD, 32'h2);
      rd(`SPSR_A_ST1, q);
      check("cmds ignored", {28'h0, q[12:9]}, 32'h1);
      rd(`SPSR_A_ST2, q);
      check("no latch", q, p);
      sw <= 1'b0;
      lost <= 1'b0;
   endtask

   task automatic t_shutdown();
      logic [31:0] q;
      logic sh;
      for (int b = 0; b < 7; b++) begin
         sh = (b == 0 || b == 1 || b == 2 || b == 6);
         wr(`SPSR_A_TGT, 32'h0000_0040);
         wr(`SPSR_A_CMD, 32'h1);
         repeat (90) @(posedge clk);
         sense <= spsr_sense_t'(7'h01 << b);
         repeat (6) @(posedge clk);
         check("hiz", {31'h0, hiz}, {31'h0, sh});
         check("pump", {31'h0, cp_en}, {31'h0, !sh});
         rd(`SPSR_A_ST1, q);
         check("flag", {31'h0, q[b]}, 32'h1);
         if (sh) begin
            check("stays down", {28'h0, q[12:9]}, 32'h8);
            rd(`SPSR_A_ST2, q);
            check("tgt copy", {16'h0, q[31:16]}, {16'h0, q[15:0]});
            sense <= '0;
            repeat (3) @(posedge clk);
            wait_state(4'h1);
            check("clk on", {31'h0, clk_en}, 32'h1);
            check("hold on", {31'h0, hold}, 32'h1);
         end
         sense <= '0;
         wr(`SPSR_A_CMD, 32'h4);
         wait_state(4'h1);
      end
   endtask

   task automatic t_search();
      logic [31:0] q;
      logic [15:0] p;
      wr(`SPSR_A_CFG, 32'h0400_0000);
      rd(`SPSR_A_ST2, q);
      p = q[15:0];
      wr(`SPSR_A_ENDS, {p + 16'h0003, p + 16'h0006});
      wr(`SPSR_A_CMD, 32'h3);
      rd(`SPSR_A_ST1, q);
      check("search on", {28'h0, q[12:9]}, 32'h3);
      wr(`SPSR_A_TGT, 32'h0000_0100);
      wr(`SPSR_A_CMD, 32'h1);
      rd(`SPSR_A_ST1, q);
      check("no preempt", {31'h0, q[12:9] inside {3, 4}}, 32'h1);
      wait_state(4'h1);
      rd(`SPSR_A_ST2, q);
      check("zeroed", {16'h0, q[15:0]}, 32'h0);
      wr(`SPSR_A_CFG, 32'h0002_0000);
      wr(`SPSR_A_ENDS, 32'h0002_0005);
      wr(`SPSR_A_CMD, 32'h3);
      wait_state(4'h1);
      rd(`SPSR_A_ST2, q);
      check("then safe", {16'h0, q[15:0]}, 32'h8);
   endtask

   task automatic t_deadlock();
      logic [31:0] q;
      wr(`SPSR_A_ENDS, 32'h0004_0004);
      wr(`SPSR_A_CMD, 32'h3);
      repeat (4) @(posedge clk);
      rd(`SPSR_A_ST1, q);
      check("deadlock", {28'h0, q[12:9]}, 32'h6);
      rd(`SPSR_A_ST1, q);
      check("query alone", {28'h0, q[12:9]}, 32'h6);
      wr(`SPSR_A_CMD, 32'h4);
      rd(`SPSR_A_ST1, q);
      rd(`SPSR_A_ST1, q);
      check("released", {28'h0, q[12:9]}, 32'h1);
      wr(`SPSR_A_ENDS, 32'h0000_0040);
      wr(`SPSR_A_CMD, 32'h3);
      wr(`SPSR_A_CMD, 32'h4);
      rd(`SPSR_A_ST1, q);
      check("halt aborts", {28'h0, q[12:9]}, 32'h1);
      rd(`SPSR_A_ST2, q);
      check("halt tgt", {16'h0, q[31:16]}, {16'h0, q[15:0]});
      check("no step hiz", {31'h0, bad}, 32'h0);
   endtask

   initial begin
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_range();
      t_safe();
      t_switch_lost();
      t_shutdown();
      t_search();
      t_deadlock();
      finish_test();
   end

   initial begin
      repeat (90000) @(posedge clk);
      error_cnt++;
      $display("[FAIL] watchdog expected done seen hang");
      finish_test();
   end
endmodule
